// [rtl/octal_switch_serial_control.sv]
/*
 * serial control and status port of an eight-output low-side switch.
 * assumes the host is the serial master; its clock is sampled by i_sys_clk.
 */
// How it works
// [R1] select low: shift commands in, drive serial out from select fall.
// [R2] select rise copies shift register to all eight output latches together.
// [R3] select fall loads the eight drain status bits into shift register.
// [R4] host drops select only while serial clock is low.
// [R5] serial input sampled on each serial clock fall while selected.
// [R6] serial output advances on each serial clock rise once a bit has been clocked in.
// [R7] host keeps serial clock low whenever select changes.
// [R8] host should keep serial clock low while deselected.
// [R9] deselected: clock and data ignored, serial out tri-stated.
// [R10] command one means output off, zero means on, applied at select rise.
// [R11] frame is eight bits, first bit controls output seven.
// [R12] shift register holds eight bits; full after eight clocked bits.
// [R13] status one for off unfaulted output, zero for on unfaulted.
// [R14] first-in first-out, msb first; status reflects previous command.
// [R15] clear input leaves serial output untouched.
// [R16] clear low empties shift register and forces outputs off.
// [R17] host holds clear low at least 250 ns.
// [R18] latch disable low: short latches output off; high: current limit.
// [R19] host avoids changing serial input at clock rise.
// [R20] after supply over-voltage, next status word reads all ones.
// [R21] output latches reset to all off and hold until a new command.
`timescale 1ns/1ps
module octal_switch_serial_control
    import octal_switch_pkg::*;
(
    // system
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    // serial pins from host
    input  wire logic       i_sel_n,
    input  wire logic       i_sclk,
    input  wire logic       i_sdi,
    input  wire logic       i_clr_n,
    input  wire logic       i_short_latch_disable,
    // analog side
    input  wire logic [7:0] i_drain_high,
    input  wire logic [7:0] i_short_fault,
    input  wire logic [7:0] i_over_temp,
    input  wire logic       i_load_supply_ov,
    // serial out pin
    output logic            o_sdo,
    output logic            o_sdo_oe,
    // output switch gates, one means on, and frame full flag
    output logic [7:0]      o_gate_on,
    output logic            o_frame_full
);
    pin_sync_if sync ();
    logic       pins_raw [5];
    logic [7:0] drain_sync_a, drain_sync_b;
    logic [7:0] short_sync_a, short_sync_b;
    logic [7:0] ot_sync_a, ot_sync_b;
    logic       ov_sync_a, ov_sync_b;

    assign pins_raw[0] = i_sel_n;
    assign pins_raw[1] = i_sclk;
    assign pins_raw[2] = i_sdi;
    assign pins_raw[3] = i_clr_n;
    assign pins_raw[4] = i_short_latch_disable;

    pin_sampler u_sampler (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_pins_raw (pins_raw),
        .sync       (sync.sampler)
    );

    // ------------------------------------------------------------
    // analog status synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drain_sync_a <= ALL_OFF;
            drain_sync_b <= ALL_OFF;
            short_sync_a <= 8'h00;
            short_sync_b <= 8'h00;
            ot_sync_a    <= 8'h00;
            ot_sync_b    <= 8'h00;
            ov_sync_a    <= 1'b0;
            ov_sync_b    <= 1'b0;
        end else begin
            drain_sync_a <= i_drain_high;
            drain_sync_b <= drain_sync_a;
            short_sync_a <= i_short_fault;
            short_sync_b <= short_sync_a;
            ot_sync_a    <= i_over_temp;
            ot_sync_b    <= ot_sync_a;
            ov_sync_a    <= i_load_supply_ov;
            ov_sync_b    <= ov_sync_a;
        end
    end

    // ------------------------------------------------------------
    // edge detection state
    // ------------------------------------------------------------
    logic       sel_d, sclk_d;
    logic       sel_fall, sel_rise, sclk_fall, sclk_rise;
    logic       clr_act;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_d  <= 1'b1;
            sclk_d <= 1'b0;
        end else begin
            sel_d  <= sync.sel_n;
            sclk_d <= sync.sclk;
        end
    end

    always_comb begin
        sel_fall  = sel_d && !sync.sel_n;
        sel_rise  = !sel_d && sync.sel_n;
        sclk_fall = sclk_d && !sync.sclk && !sync.sel_n;                    // R9
        sclk_rise = !sclk_d && sync.sclk && !sync.sel_n;                    // R9
        clr_act   = !sync.clr_n;
    end

    // ------------------------------------------------------------
    // shift path and output latches
    // ------------------------------------------------------------
    logic [7:0] shreg, next_shreg;
    logic [7:0] cmd, next_cmd;          // command latch, one = off
    logic [7:0] latched_off, next_latched_off;
    logic       ov_seen, next_ov_seen;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic       sdo, next_sdo;
    logic       sdo_oe, next_sdo_oe;
    logic [7:0] gate_on, next_gate_on;
    logic       frame_full, next_frame_full;
    logic [7:0] status_word;

    // status is the drain level: high when off and unfaulted
    always_comb begin
        status_word = drain_sync_b;                                         // R13
        if (ov_seen) begin
            status_word = ALL_OFF;                                          // R20
        end
    end

    always_comb begin
        next_shreg       = shreg;
        next_cmd         = cmd;
        next_latched_off = latched_off;
        next_ov_seen     = ov_seen;
        next_bit_cnt     = bit_cnt;
        next_sdo         = sdo;
        next_sdo_oe      = !sync.sel_n;                                     // R1 R9 R15
        next_frame_full  = (bit_cnt == CNT_FULL);                           // R12
        if (ov_sync_b) begin
            next_ov_seen = 1'b1;
        end
        if (sel_fall) begin
            next_shreg   = status_word;                                     // R3 R14
            next_sdo     = status_word[FRAME_BITS-1];                       // R1 R11
            next_bit_cnt = CNT_ZERO;
            if (!ov_sync_b) begin
                next_ov_seen = 1'b0;
            end
        end else if (sclk_fall) begin
            next_shreg = {shreg[FRAME_BITS-2:0], sync.sdi};                 // R5 R11
            if (bit_cnt != CNT_FULL) begin
                next_bit_cnt = bit_cnt + 4'h1;                              // R12
            end
        end else if (sclk_rise && bit_cnt != CNT_ZERO) begin
            next_sdo = shreg[FRAME_BITS-1];                                 // R6 R14
        end
        if (sel_rise) begin
            next_cmd         = shreg;                                       // R2 R10
            next_latched_off = 8'h00;
        end
        // shorts latch off only when latch disable is low
        if (!sync.sld) begin
            next_latched_off = next_latched_off | short_sync_b;             // R18
        end
        if (clr_act) begin
            next_shreg       = SHIFT_CLEARED;                               // R16
            next_cmd         = ALL_OFF;                                     // R16 R21
            next_latched_off = 8'h00;
            next_bit_cnt     = CNT_ZERO;
        end
        // over-voltage and over-temperature force off independent of command
        next_gate_on = ~next_cmd & ~next_latched_off & ~ot_sync_b
                       & {8{~ov_sync_b}};                                   // R10 R18
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shreg       <= SHIFT_CLEARED;
            cmd         <= ALL_OFF;                                         // R21
            latched_off <= 8'h00;
            ov_seen     <= 1'b0;
            bit_cnt     <= CNT_ZERO;
            sdo         <= 1'b0;
            sdo_oe      <= 1'b0;
            gate_on     <= 8'h00;
            frame_full  <= 1'b0;
        end else begin
            shreg       <= next_shreg;
            cmd         <= next_cmd;
            latched_off <= next_latched_off;
            ov_seen     <= next_ov_seen;
            bit_cnt     <= next_bit_cnt;
            sdo         <= next_sdo;
            sdo_oe      <= next_sdo_oe;
            gate_on     <= next_gate_on;
            frame_full  <= next_frame_full;
        end
    end

    assign o_sdo        = sdo;
    assign o_sdo_oe     = sdo_oe;
    assign o_gate_on    = gate_on;
    assign o_frame_full = frame_full;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_sel_fall;
        sel_d && !sync.sel_n;
    endsequence

    sequence s_sel_rise;
        !sel_d && sync.sel_n;
    endsequence

    a_oe_follows_sel: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R1
        ##1 (sdo_oe == !$past(sync.sel_n)))
        else $error("serial out enable does not follow select");

    a_cmd_on_rise: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R2
        s_sel_rise and !clr_act |=> (cmd == $past(shreg)))
        else $error("command latch not loaded at select rise");

    a_status_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R3
        s_sel_fall and !clr_act |=> (shreg == $past(status_word)))
        else $error("status not loaded at select fall");

    a_shift_in: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R5
        sclk_fall && !sel_fall && !clr_act |=> shreg[0] == $past(sync.sdi))
        else $error("serial input not shifted in");

    a_sdo_shift: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R6
        sclk_rise && !sel_fall && bit_cnt != CNT_ZERO |=> sdo == $past(shreg[7]))
        else $error("serial output not advanced on clock rise");

    a_idle_ignore: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R9
        sync.sel_n && sel_d && !clr_act |=> $stable(shreg) && !sdo_oe)
        else $error("activity while deselected");

    a_cnt_limit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R12
        bit_cnt <= CNT_FULL)
        else $error("bit counter past eight");

    a_clear_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R16
        clr_act |=> cmd == ALL_OFF ##1 gate_on == 8'h00)
        else $error("clear does not force outputs off");

    a_short_latch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R18
        !sync.sld && (short_sync_b != 8'h00) |=> ##1 ((gate_on & $past(short_sync_b, 2)) == 8'h00))
        else $error("shorted output not latched off");

    a_ov_status: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R20
        s_sel_fall and (ov_seen && !clr_act) |=> shreg == ALL_OFF)
        else $error("over-voltage status not all ones");
endmodule // octal_switch_serial_control

// [rtl/octal_switch_pkg.sv]
/*
 * constants for the octal switch serial control block.
 * assumes a 250 mhz system clock sampling the serial pins.
 */
package octal_switch_pkg;
    // ------------------------------------------------------------
    // frame and reset values
    // ------------------------------------------------------------
    localparam int          FRAME_BITS    = 8;
    localparam logic [7:0]  ALL_OFF       = 8'hff;
    localparam logic [7:0]  SHIFT_CLEARED = 8'h00;
    localparam logic [3:0]  CNT_ZERO      = 4'h0;
    localparam logic [3:0]  CNT_FULL      = 4'h8;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          CLR_MIN_NS    = 250;
    localparam int          CLR_MIN_CYC   = (CLR_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
    localparam int          SYNC_STAGES   = 2;
endpackage

// [rtl/pin_sync_if.sv]
/*
 * carrier for synchronised serial pins between sampler and core.
 * assumes one clock domain, the system clock.
 */
`timescale 1ns/1ps
interface pin_sync_if;
    logic sel_n;
    logic sclk;
    logic sdi;
    logic clr_n;
    logic sld;
    modport sampler (output sel_n, output sclk, output sdi, output clr_n, output sld);
    modport core    (input sel_n, input sclk, input sdi, input clr_n, input sld);
endinterface

// [rtl/pin_sampler.sv]
/*
 * two-flop synchronisers for the asynchronous pins.
 * assumes the pins come from the host, outside the system clock domain.
 */
`timescale 1ns/1ps
module pin_sampler
    import octal_switch_pkg::*;
(
    // clock and reset
    input  wire logic   i_sys_clk,
    input  wire logic   i_rst_n,
    // raw pins: select, clock, data, clear, short latch disable
    input  wire logic   i_pins_raw [5],
    // synchronised
    pin_sync_if.sampler sync
);
    logic [4:0] stage [SYNC_STAGES];

    // ------------------------------------------------------------
    // synchroniser chain
    // ------------------------------------------------------------
    // select idles high, clear idles low (pull-down): reset to idle levels
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int s = 0; s < SYNC_STAGES; s++) begin
                stage[s] <= 5'h01;
            end
        end else begin
            stage[0] <= {i_pins_raw[4], i_pins_raw[3], i_pins_raw[2],
                         i_pins_raw[1], i_pins_raw[0]};
            for (int s = 1; s < SYNC_STAGES; s++) begin
                stage[s] <= stage[s-1];
            end
        end
    end

    assign sync.sel_n = stage[SYNC_STAGES-1][0];
    assign sync.sclk  = stage[SYNC_STAGES-1][1];
    assign sync.sdi   = stage[SYNC_STAGES-1][2];
    assign sync.clr_n = stage[SYNC_STAGES-1][3];
    assign sync.sld   = stage[SYNC_STAGES-1][4];
endmodule // pin_sampler

// [test/spi_host_model.sv]
/*
 * serial master model driving select, clock and data.
 * assumes the bench calls its tasks; pins change on system clock falls.
 */
`timescale 1ns/1ps
module spi_host_model (
    // system clock
    input  wire logic i_sys_clk,
    // serial out from device
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe,
    // host pins
    output logic      o_sel_n,
    output logic      o_sclk,
    output logic      o_sdi
);
    logic last_so;
    logic miso;
    initial begin
        o_sel_n = 1'b1;
        o_sclk  = 1'b0;
        o_sdi   = 1'b0;
        last_so = 1'b0;
    end
    always @(posedge i_sys_clk) if (i_sdo_oe) last_so <= i_sdo;
    // released line must not show a stale bit
    assign miso = i_sdo_oe ? i_sdo : ~last_so;
    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    task automatic begin_frame();
        wait_clk(1);
        o_sclk  = 1'b0;
        o_sel_n = 1'b0;
        wait_clk(10);
    endtask
    task automatic shift_byte(input logic [7:0] cmd, output logic [7:0] st);
        for (int i = 7; i >= 0; i--) begin
            o_sdi = cmd[i];
            wait_clk(5);
            o_sclk = 1'b1;
            wait_clk(10);
            st[i] = miso;
            o_sclk = 1'b0;
            wait_clk(5);
        end
    endtask
    task automatic end_frame();
        wait_clk(5);
        o_sel_n = 1'b1;
        wait_clk(10);
    endtask
endmodule // spi_host_model

// [test/tb_top.sv]
/*
 * self-checking bench for the octal switch serial port.
 * assumes a load that pulls each drain high while its gate is off.
 */
`timescale 1ns/1ps
module tb_top
    import octal_switch_pkg::*;
;
    logic       sys_clk;
    logic       rst_n;
    logic       clr_n;
    logic       sld;
    logic       ov;
    logic [7:0] fault;
    logic [7:0] ot;
    logic [7:0] gate_on;
    logic [7:0] drain_high;
    logic [7:0] st;
    logic       sel_n;
    logic       sclk;
    logic       sdi;
    logic       sdo;
    logic       sdo_oe;
    logic       full;
    int         n_mismatch;
    int         checks_done;
    int         cycles;
    assign drain_high = ~gate_on;
    spi_host_model host (.i_sys_clk(sys_clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
        .o_sel_n(sel_n), .o_sclk(sclk), .o_sdi(sdi));
    octal_switch_serial_control dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_sel_n(sel_n), .i_sclk(sclk), .i_sdi(sdi), .i_clr_n(clr_n),
        .i_short_latch_disable(sld), .i_drain_high(drain_high),
        .i_short_fault(fault), .i_over_temp(ot), .i_load_supply_ov(ov),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_gate_on(gate_on), .o_frame_full(full));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] cmd);
        host.begin_frame();
        host.shift_byte(cmd, st);
        check8("frame_full", 8'h01, {7'h00, full});
        host.end_frame();
    endtask
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_first();
        check8("gate reset", 8'h00, gate_on);
        host.begin_frame();
        check8("oe selected", 8'h01, {7'h00, sdo_oe});
        host.shift_byte(8'h5a, st);
        host.end_frame();
        check8("status", ALL_OFF, st);
        check8("gate", 8'ha5, gate_on);
        check8("oe idle", 8'h00, {7'h00, sdo_oe});
        xfer(8'h0f);
        check8("status", 8'h5a, st);
    endtask
    task automatic t_ignore();
        // clock activity while deselected is legal, only discouraged
        for (int i = 0; i < 8; i++) begin
            host.o_sdi = ~host.o_sdi;
            host.o_sclk = ~host.o_sclk;
            host.wait_clk(10);
        end
        check8("gate", 8'hf0, gate_on);
        xfer(8'h0f);
        check8("status", 8'h0f, st);
    endtask
    task automatic t_clear();
        host.begin_frame();
        clr_n = 1'b0;
        host.wait_clk(70);
        check8("gate clr", 8'h00, gate_on);
        check8("oe clr", 8'h01, {7'h00, sdo_oe});
        clr_n = 1'b1;
        host.wait_clk(4);
        host.shift_byte(8'h00, st);
        host.end_frame();
        check8("status clr", 8'h00, st);
        check8("gate", 8'hff, gate_on);
    endtask
    task automatic t_short();
        fault = 8'h08;
        host.wait_clk(8);
        check8("latch off", 8'hf7, gate_on);
        fault = 8'h00;
        host.wait_clk(8);
        check8("latched", 8'hf7, gate_on);
        xfer(8'h00);
        check8("status", 8'h08, st);
        sld = 1'b1;
        fault = 8'h08;
        host.wait_clk(8);
        check8("limit", 8'hff, gate_on);
        // thermal shutdown forces off only while it stands
        ot = 8'ha5;
        host.wait_clk(8);
        check8("over temp", 8'h5a, gate_on);
        ot = 8'h00;
        host.wait_clk(8);
        check8("temp release", 8'hff, gate_on);
        fault = 8'h00;
    endtask
    task automatic t_ov();
        ov = 1'b1;
        host.wait_clk(8);
        check8("ov off", 8'h00, gate_on);
        ov = 1'b0;
        host.wait_clk(8);
        // outputs follow the command again once the over-voltage is gone
        check8("ov release", 8'hff, gate_on);
        xfer(8'h3c);
        check8("status", ALL_OFF, st);
        check8("gate", 8'hc3, gate_on);
    endtask
    // ------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        rst_n = 1'b0;
        clr_n = 1'b1;
        sld = 1'b0;
        ov = 1'b0;
        fault = 8'h00;
        ot = 8'h00;
        n_mismatch = 0;
        checks_done = 0;
        cycles = 0;
        host.wait_clk(2);
        rst_n = 1'b1;
        host.wait_clk(6);
        t_first();
        t_ignore();
        t_clear();
        t_short();
        t_ov();
        stop_test();
    end
endmodule // tb_top
